// File: output_divider_skew_control_cfg.svh
// constants for the output divider and skew block
// assumes inclusion by bare name from the package and the design modules
`ifndef OUTPUT_DIVIDER_SKEW_CONTROL_CFG_SVH
`define OUTPUT_DIVIDER_SKEW_CONTROL_CFG_SVH

// --------
// structure
// --------
`define ODS_DIV_PER_ENGINE 4
`define ODS_NUM_ENGINES 2
`define ODS_HALF_W 16
`define ODS_SKEW_W 8
`define ODS_FINE_W 4
`define ODS_RATIO_W 16
`define ODS_DCO_W 16
`define ODS_REF_SEL_W 2

// --------
// frequency ceilings per output kind, in hz
// --------
`define ODS_HS_CLK_HZ 40000000
`define ODS_FMAX_HP_DIFF_HZ 750000000
`define ODS_FMAX_HP_SE_HZ 177500000
`define ODS_FMAX_CFG_SE_HZ 160000000
`define ODS_FMAX_CFG_DIFF_HZ 350000000

// --------
// rate conversion ratios, reduced to fit 16 bits after x4
// --------
`define ODS_FB_255 16'h00ff
`define ODS_FWD_237 16'h00ed
`define ODS_FWD_238 16'h00ee
`define ODS_FB_66 16'h0021
`define ODS_FWD_64 16'h0020
`define ODS_FB_DBL 16'h20df
`define ODS_FWD_DBL_238 16'h1dc0
`define ODS_FWD_DBL_237 16'h1da0
`define ODS_FB_UNITY 16'h0001
`define ODS_FWD_UNITY 16'h0001

// --------
// reset values and forbidden feedback product
// --------
`define ODS_DCO_RST 16'h0000
`define ODS_FB_FORBIDDEN_PRODUCT 64'd65536000

`endif

// File: output_divider_skew_control_pkg.sv
// types shared by the output divider and skew block
// assumes the cfg header is on the include path
`default_nettype none
`include "output_divider_skew_control_cfg.svh"

package output_divider_skew_control_pkg;

    // --------
    // output kind decides frequency ceiling and skew support
    // --------
    typedef enum logic [1:0] {
        KIND_HP_DIFF = 2'h0,
        KIND_HP_SE = 2'h1,
        KIND_CFG_BANK = 2'h2
    } out_kind_t;

    // rate conversion choices
    typedef enum logic [2:0] {
        RATE_NONE = 3'h0,
        RATE_255_237 = 3'h1,
        RATE_255_238 = 3'h2,
        RATE_66_64 = 3'h3,
        RATE_66_64_255_238 = 3'h4,
        RATE_66_64_255_237 = 3'h5
    } rate_sel_t;

    // optional x2 or x4 multiplication of the converted rate
    typedef enum logic [1:0] {
        MULT_X1 = 2'h0,
        MULT_X2 = 2'h1,
        MULT_X4 = 2'h2
    } rate_mult_t;

    // per divider configuration
    typedef struct packed {
        logic enable;
        out_kind_t kind;
        logic [`ODS_HALF_W-1:0] half;
        logic [`ODS_SKEW_W-1:0] skew;
        logic [`ODS_FINE_W-1:0] fine;
        logic stop_sw;
        logic stop_on_rise;
        logic stop_gpio_en;
    } div_cfg_t;

    // rate converter divider pair
    typedef struct packed {
        logic [`ODS_RATIO_W-1:0] fwd;
        logic [`ODS_RATIO_W-1:0] fb;
    } ratio_t;

endpackage
`default_nettype wire

// File: ods_div_chan.sv
// one 50% duty divider channel with coarse skew and edge-selected stop
// assumes a synchronous reset release and same-clock control inputs
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_skew_control_cfg.svh"

module ods_div_chan (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic enable_i,
    input wire logic [`ODS_HALF_W-1:0] half_i,
    input wire logic [`ODS_SKEW_W-1:0] skew_i,
    input wire logic stop_i,
    input wire logic stop_on_rise_i,
    // output clock
    output logic clk_o,
    output logic stopped_o
);

    // --------
    // state
    // --------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SKEW = 4'h2,
        ST_RUN = 4'h4,
        ST_STOP = 4'h8
    } chan_state_t;

    chan_state_t state_reg; // channel state
    chan_state_t state_next;
    logic [`ODS_HALF_W-1:0] cnt_reg; // half period counter
    logic [`ODS_SKEW_W-1:0] skew_reg; // coarse skew countdown
    logic out_reg; // output level

    // half boundary: counter wraps and level toggles here
    wire boundary = (cnt_reg >= half_i - 16'h0001);
    wire new_level = ~out_reg;
    // stop lands right after the chosen edge, so no runt pulse
    wire stop_here = stop_i && boundary && (new_level == stop_on_rise_i);

    // --------
    // next state
    // --------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (enable_i) state_next = ST_SKEW;
            end
            ST_SKEW: begin
                // coarse skew: one high speed period per step
                if (skew_reg == 8'h00) state_next = ST_RUN;
            end
            ST_RUN: begin
                if (stop_here) state_next = ST_STOP;
            end
            ST_STOP: begin
                // resume only on a whole half period boundary
                if (!stop_i && boundary) state_next = ST_RUN;
            end
            default: state_next = ST_IDLE;
        endcase
        if (!enable_i) state_next = ST_IDLE;
    end

    // --------
    // registers
    // --------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            skew_reg <= 8'h00;
            out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // counter keeps running while stopped to keep phase
            if (state_reg == ST_RUN || state_reg == ST_STOP) begin
                cnt_reg <= boundary ? 16'h0000 : cnt_reg + 16'h0001;
            end else begin
                cnt_reg <= 16'h0000;
            end
            if (state_reg == ST_IDLE) begin
                skew_reg <= skew_i;
                out_reg <= 1'b0;
            end else if (state_reg == ST_SKEW) begin
                skew_reg <= skew_reg - 8'h01;
            end
            // equal halves give the 50% duty cycle
            if (boundary && (state_reg == ST_RUN || state_next == ST_RUN)) begin
                out_reg <= new_level;
            end
        end
    end

    assign clk_o = out_reg;
    assign stopped_o = (state_reg == ST_STOP);

endmodule // ods_div_chan
`default_nettype wire

// File: output_divider_skew_control.sv
// top of the output divider, skew, dco trim and rate ratio block
// assumes mclk_i is the synthesizer clock; gpio stops arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_skew_control_cfg.svh"

// Behaviour
// - four independent dividers per synthesis engine
// - differential dividers up to 750 MHz, 50% duty
// - single-ended limits 160 and 177.5 MHz
// - configurable bank differential limited to 350 MHz
// - coarse skew step equals one fast period
// - fine sub-period skew for single-ended outputs
// - stop on rising or falling edge
// - bank is four single ended or four differential, set per engine
// - dco trim only honoured while locked
// - one trim setting drives all active dcos
// - external feedback through reference 0 to 3
// - 255/237 scaling with x2 or x4
// - 66/64 optionally cascaded with 255/238 or 255/237
// - sixteen bit forward and feedback dividers
module output_divider_skew_control #(
    parameter int NUM_ENG = `ODS_NUM_ENGINES,
    parameter int DIV_PER_ENG = `ODS_DIV_PER_ENGINE,
    parameter longint HS_CLK_HZ = `ODS_HS_CLK_HZ
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // divider configuration and gpio stop pins
    input var output_divider_skew_control_pkg::div_cfg_t div_cfg_i [NUM_ENG*DIV_PER_ENG],
    input wire logic [NUM_ENG*DIV_PER_ENG-1:0] gpio_stop_i,
    input wire logic [1:0] bank_diff_i,
    // dco trim
    input wire logic locked_i,
    input wire logic dco_trim_we_i,
    input wire logic [`ODS_DCO_W-1:0] dco_trim_i,
    input wire logic [NUM_ENG-1:0] dco_active_i,
    // external feedback and rate conversion
    input wire logic fb_ext_en_i,
    input wire logic [`ODS_REF_SEL_W-1:0] fb_ref_sel_i,
    input wire logic [63:0] fb_product_i,
    input var output_divider_skew_control_pkg::rate_sel_t rate_sel_i,
    input var output_divider_skew_control_pkg::rate_mult_t rate_mult_i,
    // output clocks and status
    output logic [NUM_ENG*DIV_PER_ENG-1:0] clk_o,
    output logic [NUM_ENG*DIV_PER_ENG-1:0] clk_n_o,
    output logic [NUM_ENG*DIV_PER_ENG-1:0] stopped_o,
    output logic [NUM_ENG*DIV_PER_ENG*`ODS_FINE_W-1:0] fine_tap_o,
    output logic [NUM_ENG*DIV_PER_ENG-1:0] half_clamped_o,
    output logic [NUM_ENG*`ODS_DCO_W-1:0] dco_trim_o,
    output logic [3:0] fb_ref_onehot_o,
    output logic fb_forbidden_o,
    output output_divider_skew_control_pkg::ratio_t ratio_o
);

    localparam int NDIV = NUM_ENG * DIV_PER_ENG;

    // --------
    // minimum half period per kind: ceil(fclk / (2 * fmax)), at least 1
    // --------
    function automatic logic [`ODS_HALF_W-1:0] min_half(input longint fmax);
        longint q;
        q = (HS_CLK_HZ + 2 * fmax - 1) / (2 * fmax);
        if (q < 1) q = 1;
        return q[`ODS_HALF_W-1:0];
    endfunction

    localparam logic [`ODS_HALF_W-1:0] MIN_HP_DIFF = min_half(`ODS_FMAX_HP_DIFF_HZ);
    localparam logic [`ODS_HALF_W-1:0] MIN_HP_SE = min_half(`ODS_FMAX_HP_SE_HZ);
    localparam logic [`ODS_HALF_W-1:0] MIN_CFG_SE = min_half(`ODS_FMAX_CFG_SE_HZ);
    localparam logic [`ODS_HALF_W-1:0] MIN_CFG_DIFF = min_half(`ODS_FMAX_CFG_DIFF_HZ);

    // --------
    // reset release through two flops
    // --------
    logic [1:0] rst_sync_reg; // reset release chain
    logic rst_n; // synchronised reset for the whole block

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_sync_reg <= 2'b00;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // --------
    // divider channels
    // --------
    genvar gi;
    generate
        for (gi = 0; gi < NDIV; gi++) begin : g_chan
            // bank index: cfg banks split across the two engines
            localparam int BANK = (gi / DIV_PER_ENG) % 2;
            logic [2:0] gpio_sync_reg; // three flop input chain
            logic gpio_stop_reg; // accepted level, stage 2 and 3 agree
            logic [`ODS_HALF_W-1:0] floor_half; // per-kind lowest half
            logic [`ODS_HALF_W-1:0] eff_half; // clamped half period
            logic is_se; // single ended path
            logic bank_diff; // bank running differential
            logic stop_req; // combined software and gpio stop
            logic [`ODS_FINE_W-1:0] fine_reg; // fine delay tap
            logic chan_clk; // divider output

            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) begin
                    gpio_sync_reg <= 3'b000;
                    gpio_stop_reg <= 1'b0;
                end else begin
                    gpio_sync_reg <= {gpio_sync_reg[1:0], gpio_stop_i[gi]};
                    // first flop is read by the second only
                    if (gpio_sync_reg[1] == gpio_sync_reg[2]) begin
                        gpio_stop_reg <= gpio_sync_reg[2];
                    end
                end
            end

            assign bank_diff = (div_cfg_i[gi].kind == output_divider_skew_control_pkg::KIND_CFG_BANK)
                && bank_diff_i[BANK];
            assign is_se = (div_cfg_i[gi].kind != output_divider_skew_control_pkg::KIND_HP_DIFF)
                && !bank_diff;
            // frequency ceiling per kind, enforced as a half period floor
            assign floor_half =
                (div_cfg_i[gi].kind == output_divider_skew_control_pkg::KIND_HP_DIFF) ? MIN_HP_DIFF :
                (div_cfg_i[gi].kind == output_divider_skew_control_pkg::KIND_HP_SE) ? MIN_HP_SE :
                bank_diff ? MIN_CFG_DIFF : MIN_CFG_SE;
            assign eff_half = (div_cfg_i[gi].half < floor_half) ? floor_half : div_cfg_i[gi].half;
            // skew and stop belong to single ended outputs only
            assign stop_req = is_se && (div_cfg_i[gi].stop_sw
                || (div_cfg_i[gi].stop_gpio_en && gpio_stop_reg));

            ods_div_chan u_chan (
                .clk_i(mclk_i),
                .rst_n_i(rst_n),
                .enable_i(div_cfg_i[gi].enable),
                .half_i(eff_half),
                .skew_i(is_se ? div_cfg_i[gi].skew : 8'h00),
                .stop_i(stop_req),
                .stop_on_rise_i(div_cfg_i[gi].stop_on_rise),
                .clk_o(chan_clk),
                .stopped_o(stopped_o[gi])
            );

            // fine tap drives the analog delay line of the output
            always_ff @(posedge mclk_i or negedge rst_n) begin
                if (!rst_n) fine_reg <= 4'h0;
                else fine_reg <= is_se ? div_cfg_i[gi].fine : 4'h0;
            end

            assign clk_o[gi] = chan_clk;
            // differential pairs carry the inverse on the n leg
            assign clk_n_o[gi] = is_se ? 1'b0 : ~chan_clk;
            assign fine_tap_o[gi*`ODS_FINE_W +: `ODS_FINE_W] = fine_reg;
            assign half_clamped_o[gi] = (div_cfg_i[gi].half < floor_half);
        end
    endgenerate

    // --------
    // dco centre trim, one setting shared, accepted only when locked
    // --------
    logic [`ODS_DCO_W-1:0] dco_trim_reg; // shared trim value
    wire dco_take = dco_trim_we_i && locked_i;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) dco_trim_reg <= `ODS_DCO_RST;
        else if (dco_take) dco_trim_reg <= dco_trim_i;
    end

    generate
        for (gi = 0; gi < NUM_ENG; gi++) begin : g_dco
            // inactive dcos get zero so they keep their own centre
            assign dco_trim_o[gi*`ODS_DCO_W +: `ODS_DCO_W] =
                dco_active_i[gi] ? dco_trim_reg : `ODS_DCO_RST;
        end
    endgenerate

    // --------
    // external feedback reference select
    // --------
    logic [3:0] fb_ref_reg; // one-hot feedback reference
    // flag only: software owns the check, hardware reports it
    assign fb_forbidden_o = fb_ext_en_i && (fb_product_i == `ODS_FB_FORBIDDEN_PRODUCT);

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) fb_ref_reg <= 4'h0;
        else fb_ref_reg <= fb_ext_en_i ? (4'h1 << fb_ref_sel_i) : 4'h0;
    end
    assign fb_ref_onehot_o = fb_ref_reg;

    // --------
    // rate converter ratio, fractions reduced so x4 fits 16 bits
    // --------
    output_divider_skew_control_pkg::ratio_t base_ratio; // before x2/x4
    output_divider_skew_control_pkg::ratio_t ratio_reg; // registered ratio

    always_comb begin
        case (rate_sel_i)
            output_divider_skew_control_pkg::RATE_255_237:
                base_ratio = '{fwd: `ODS_FWD_237, fb: `ODS_FB_255};
            output_divider_skew_control_pkg::RATE_255_238:
                base_ratio = '{fwd: `ODS_FWD_238, fb: `ODS_FB_255};
            output_divider_skew_control_pkg::RATE_66_64:
                base_ratio = '{fwd: `ODS_FWD_64, fb: `ODS_FB_66};
            output_divider_skew_control_pkg::RATE_66_64_255_238:
                base_ratio = '{fwd: `ODS_FWD_DBL_238, fb: `ODS_FB_DBL};
            output_divider_skew_control_pkg::RATE_66_64_255_237:
                base_ratio = '{fwd: `ODS_FWD_DBL_237, fb: `ODS_FB_DBL};
            default:
                base_ratio = '{fwd: `ODS_FWD_UNITY, fb: `ODS_FB_UNITY};
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ratio_reg <= '{fwd: `ODS_FWD_UNITY, fb: `ODS_FB_UNITY};
        end else begin
            ratio_reg.fwd <= base_ratio.fwd;
            case (rate_mult_i)
                output_divider_skew_control_pkg::MULT_X2: ratio_reg.fb <= base_ratio.fb << 1;
                output_divider_skew_control_pkg::MULT_X4: ratio_reg.fb <= base_ratio.fb << 2;
                default: ratio_reg.fb <= base_ratio.fb;
            endcase
        end
    end
    assign ratio_o = ratio_reg;

endmodule // output_divider_skew_control
`default_nettype wire

// File: output_divider_skew_control_assertions.sv
// concurrent checks on the output divider and skew block top ports
// assumes binding to the top; its reset copy lags rst_n_i by two edges
`timescale 1ns/1ps
`default_nettype none
`include "output_divider_skew_control_cfg.svh"

module ods_checker #(
    parameter int NUM_ENG = 2,
    parameter int DIV_PER_ENG = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // watched inputs
    input var output_divider_skew_control_pkg::div_cfg_t div_cfg_i [NUM_ENG*DIV_PER_ENG],
    input wire logic locked_i,
    input wire logic dco_trim_we_i,
    input wire logic [`ODS_DCO_W-1:0] dco_trim_i,
    input wire logic [NUM_ENG-1:0] dco_active_i,
    input wire logic fb_ext_en_i,
    input wire logic [`ODS_REF_SEL_W-1:0] fb_ref_sel_i,
    input wire logic [63:0] fb_product_i,
    input var output_divider_skew_control_pkg::rate_sel_t rate_sel_i,
    input var output_divider_skew_control_pkg::rate_mult_t rate_mult_i,
    // watched outputs
    input wire logic [NUM_ENG*DIV_PER_ENG-1:0] clk_o,
    input wire logic [NUM_ENG*DIV_PER_ENG-1:0] clk_n_o,
    input wire logic [NUM_ENG*DIV_PER_ENG-1:0] stopped_o,
    input wire logic [NUM_ENG*`ODS_DCO_W-1:0] dco_trim_o,
    input wire logic [3:0] fb_ref_onehot_o,
    input wire logic fb_forbidden_o,
    input var output_divider_skew_control_pkg::ratio_t ratio_o
);
    // --------
    // settle counter: registered outputs lag reset release by three edges
    // --------
    logic [1:0] rcnt_reg; // edges since release, saturating
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rcnt_reg <= 2'h0;
        end else if (rcnt_reg != 2'h3) begin
            rcnt_reg <= rcnt_reg + 2'h1;
        end
    end
    wire logic rdy = (rcnt_reg == 2'h3); // internal reset surely gone

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // --------
    // assertions
    // --------
    dco_hold_a: assert property (rdy && !(dco_trim_we_i && locked_i) ##1 $stable(dco_active_i) |-> $stable(dco_trim_o))
        else $error("dco trim moved without a locked write");
    dco_take_a: assert property (rdy && dco_trim_we_i && locked_i && (&dco_active_i) |=> dco_trim_o == {NUM_ENG{$past(dco_trim_i)}})
        else $error("locked trim write not seen on every active dco");
    dco_idle_a: assert property (!dco_active_i[NUM_ENG-1] |-> dco_trim_o[NUM_ENG*`ODS_DCO_W-1 -: `ODS_DCO_W] == '0)
        else $error("inactive dco carries a trim");
    fb_sel_a: assert property (rdy && fb_ext_en_i |=> fb_ref_onehot_o == (4'h1 << $past(fb_ref_sel_i)))
        else $error("feedback reference select wrong");
    fb_off_a: assert property (rdy && !fb_ext_en_i |=> fb_ref_onehot_o == 4'h0)
        else $error("feedback reference active while disabled");
    fb_flag_a: assert property (fb_forbidden_o == (fb_ext_en_i && fb_product_i == `ODS_FB_FORBIDDEN_PRODUCT))
        else $error("forbidden feedback flag wrong");
    ratio_x4_a: assert property (rdy && rate_sel_i == output_divider_skew_control_pkg::RATE_255_237 && rate_mult_i == output_divider_skew_control_pkg::MULT_X4 |=> ratio_o == {16'h00ed, 16'h03fc})
        else $error("x4 ratio wrong");
    diff_comp_a: assert property (div_cfg_i[0].kind == output_divider_skew_control_pkg::KIND_HP_DIFF |-> clk_n_o[0] == !clk_o[0])
        else $error("differential complement wrong");
    se_comp_a: assert property (div_cfg_i[1].kind == output_divider_skew_control_pkg::KIND_HP_SE |-> !clk_n_o[1])
        else $error("single ended complement not low");
    duty_a: assert property ($rose(clk_o[0]) && div_cfg_i[0].enable && div_cfg_i[0].half == 16'h0002 |-> clk_o[0] [*2] ##1 !clk_o[0] [*2] ##1 clk_o[0])
        else $error("duty cycle not even");
    stop_hi_a: assert property (stopped_o[1] && div_cfg_i[1].stop_on_rise |-> clk_o[1])
        else $error("rise stop not parked high");
    stop_lo_a: assert property (stopped_o[1] && !div_cfg_i[1].stop_on_rise |-> !clk_o[1])
        else $error("fall stop not parked low");

    // main scenarios reached
    cover property (rdy && dco_trim_we_i && locked_i);
    cover property ($rose(stopped_o[1]));
    cover property (fb_forbidden_o);
endmodule // ods_checker

bind output_divider_skew_control ods_checker #(.NUM_ENG(NUM_ENG), .DIV_PER_ENG(DIV_PER_ENG)) ods_checker_i (
    .mclk_i, .rst_n_i, .div_cfg_i, .locked_i, .dco_trim_we_i, .dco_trim_i, .dco_active_i,
    .fb_ext_en_i, .fb_ref_sel_i, .fb_product_i, .rate_sel_i, .rate_mult_i, .clk_o, .clk_n_o,
    .stopped_o, .dco_trim_o, .fb_ref_onehot_o, .fb_forbidden_o, .ratio_o
);
`default_nettype wire

// File: output_divider_skew_control_tb_top.sv
// directed testbench for the output divider and skew block
// assumes default parameters: two engines of four dividers, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none

module output_divider_skew_control_tb_top;
    // --------
    // stimulus and observed signals
    // --------
    logic mclk_i;
    logic rst_n_i;
    output_divider_skew_control_pkg::div_cfg_t cfg [8]; // per divider setup
    logic [7:0] gpio_stop;
    logic [1:0] bank_diff;
    logic locked, dco_we;
    logic [15:0] dco_trim;
    logic [1:0] dco_act;
    logic fb_en;
    logic [1:0] fb_sel;
    logic [63:0] fb_prod;
    output_divider_skew_control_pkg::rate_sel_t rate_sel;
    output_divider_skew_control_pkg::rate_mult_t rate_mult;
    logic [7:0] clk, clk_n, stopped, clamped;
    logic [31:0] fine_tap, dco_o;
    logic [3:0] onehot;
    logic forbid;
    output_divider_skew_control_pkg::ratio_t ratio;
    int fails = 0;
    int compares = 0;
    // expected ratio pairs of each conversion, 66/64 reduced to 33/32
    logic [15:0] fb_tab [6] = '{16'h0001, 16'h00ff, 16'h00ff, 16'h0021, 16'h20df, 16'h20df};
    logic [15:0] fwd_tab [6] = '{16'h0001, 16'h00ed, 16'h00ee, 16'h0020, 16'h1dc0, 16'h1da0};

    output_divider_skew_control output_divider_skew_control_i (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .div_cfg_i(cfg), .gpio_stop_i(gpio_stop),
        .bank_diff_i(bank_diff), .locked_i(locked), .dco_trim_we_i(dco_we),
        .dco_trim_i(dco_trim), .dco_active_i(dco_act), .fb_ext_en_i(fb_en),
        .fb_ref_sel_i(fb_sel), .fb_product_i(fb_prod), .rate_sel_i(rate_sel),
        .rate_mult_i(rate_mult), .clk_o(clk), .clk_n_o(clk_n), .stopped_o(stopped),
        .fine_tap_o(fine_tap), .half_clamped_o(clamped), .dco_trim_o(dco_o),
        .fb_ref_onehot_o(onehot), .fb_forbidden_o(forbid), .ratio_o(ratio)
    );

    // --------
    // clock, watchdog and helpers
    // --------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // whole run is well under 1000 cycles; cut a hang at 4000
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // four-state compare so an unknown never matches
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // run of lvl on divider i: next whole one, or the current one
    task automatic run_len(input int i, input logic lvl, input bit whole, output int n);
        int w;
        n = 0;
        w = 0;
        while (whole && clk[i] === lvl && w < 100) begin tick(1); #1; w++; end
        while (clk[i] !== lvl && w < 200) begin tick(1); #1; w++; end
        while (clk[i] === lvl && n < 100) begin tick(1); #1; n++; end
    endtask

    // wait for divider 1 stop state, bounded; caller compares
    task automatic wait_stop(input logic lvl);
        int w;
        w = 0;
        while (stopped[1] !== lvl && w < 50) begin tick(1); #1; w++; end
    endtask

    function automatic output_divider_skew_control_pkg::div_cfg_t mk(
        input output_divider_skew_control_pkg::out_kind_t k, input logic [15:0] h,
        input logic [7:0] s, input logic [3:0] f);
        mk = '{1'b1, k, h, s, f, 1'b0, 1'b0, 1'b0};
    endfunction

    // --------
    // main sequence
    // --------
    initial begin
        int t2, t3, n;
        rst_n_i = 1'b0;
        for (int i = 0; i < 8; i++) cfg[i] = '0;
        {gpio_stop, bank_diff, locked, dco_we, dco_trim, dco_act} = '0;
        {fb_en, fb_sel, fb_prod} = '0;
        rate_sel = output_divider_skew_control_pkg::RATE_NONE;
        rate_mult = output_divider_skew_control_pkg::MULT_X1;
        tick(5);
        rst_n_i <= 1'b1;
        tick(3);
        // dividers 0 to 3 and 7 start at one edge; 3 and 2 differ by skew and fine tap
        cfg[0] <= mk(output_divider_skew_control_pkg::KIND_HP_DIFF, 16'h0002, 8'h00, 4'h5);
        cfg[1] <= mk(output_divider_skew_control_pkg::KIND_HP_SE, 16'h0003, 8'h00, 4'h0);
        cfg[2] <= mk(output_divider_skew_control_pkg::KIND_HP_SE, 16'h0002, 8'h00, 4'h5);
        cfg[3] <= mk(output_divider_skew_control_pkg::KIND_HP_SE, 16'h0002, 8'h03, 4'h0);
        cfg[7] <= mk(output_divider_skew_control_pkg::KIND_CFG_BANK, 16'h0000, 8'h00, 4'h0);
        bank_diff <= 2'h2;
        t2 = -1;
        t3 = -1;
        // odd count leaves divider 7 low at the end
        for (int t = 0; t < 39; t++) begin
            tick(1);
            #1;
            if (clk[2] === 1'b1 && t2 < 0) t2 = t;
            if (clk[3] === 1'b1 && t3 < 0) t3 = t;
        end
        cmp("skew_gap", 32'h3, 32'(t3 - t2));
        cmp("fine_se", 32'h5, 32'(fine_tap[11:8]));
        cmp("fine_diff", 32'h0, 32'(fine_tap[3:0]));
        cmp("clamp_low", 32'h1, 32'(clamped[7]));
        cmp("clamp_ok", 32'h0, 32'(clamped[2]));
        cmp("bank_diff", 32'(!clk[7]), 32'(clk_n[7]));
        run_len(1, 1'b1, 1'b1, n);
        cmp("high_half", 32'h3, 32'(n));
        run_len(3, 1'b0, 1'b1, n);
        cmp("skewed_low", 32'h2, 32'(n));
        // stop on rise from the serial control, then clean restart
        tick(1);
        cfg[1].stop_on_rise <= 1'b1;
        cfg[1].stop_sw <= 1'b1;
        wait_stop(1'b1);
        cmp("stop_sw", 32'h1, 32'(stopped[1]));
        tick(10);
        #1;
        cmp("parked_high", 32'h1, 32'(clk[1]));
        tick(1);
        cfg[1].stop_sw <= 1'b0;
        wait_stop(1'b0);
        run_len(1, 1'b0, 1'b0, n);
        cmp("restart_low", 32'h3, 32'(n));
        // stop on fall from the gpio pin
        tick(1);
        cfg[1].stop_on_rise <= 1'b0;
        cfg[1].stop_gpio_en <= 1'b1;
        gpio_stop[1] <= 1'b1;
        wait_stop(1'b1);
        cmp("stop_gpio", 32'h1, 32'(stopped[1]));
        cmp("parked_low", 32'h0, 32'(clk[1]));
        tick(1);
        gpio_stop[1] <= 1'b0;
        wait_stop(1'b0);
        run_len(1, 1'b1, 1'b0, n);
        cmp("restart_high", 32'h3, 32'(n));
        // trim refused unlocked, then shared by both dcos
        tick(1);
        {dco_act, dco_trim, dco_we} <= {2'h3, 16'h1234, 1'b1};
        tick(1);
        dco_we <= 1'b0;
        tick(2);
        #1;
        cmp("trim_unlocked", 32'h0, dco_o);
        tick(1);
        {locked, dco_we} <= 2'h3;
        tick(1);
        dco_we <= 1'b0;
        tick(1);
        #1;
        cmp("trim_all", 32'h12341234, dco_o);
        tick(1);
        dco_act <= 2'h1;
        tick(1);
        #1;
        cmp("trim_active", 32'h00001234, dco_o);
        // every feedback reference, then the forbidden product flag
        for (int s = 0; s < 4; s++) begin
            tick(1);
            {fb_en, fb_sel} <= {1'b1, 2'(s)};
            tick(2);
            #1;
            cmp("fb_onehot", 32'(4'h1 << s), 32'(onehot));
        end
        tick(1);
        fb_prod <= 64'd65536000;
        tick(1);
        #1;
        cmp("fb_forbid", 32'h1, 32'(forbid));
        tick(1);
        fb_en <= 1'b0;
        tick(2);
        #1;
        cmp("fb_off", 32'h0, {27'h0, forbid, onehot});
        // every conversion with every multiplier, except no conversion at x1 only
        for (int s = 0; s < 6; s++) begin
            for (int m = 0; m < 3; m++) begin
                if (s == 0 && m > 0) continue;
                tick(1);
                rate_sel <= output_divider_skew_control_pkg::rate_sel_t'(s);
                rate_mult <= output_divider_skew_control_pkg::rate_mult_t'(m);
                tick(2);
                #1;
                cmp("ratio", {fwd_tab[s], 16'(fb_tab[s] << m)}, ratio);
            end
        end
        report_and_stop();
    end
endmodule // output_divider_skew_control_tb_top
`default_nettype wire
